// ==== hdl/adc_ctrl_defines.svh ====
// adc_ctrl_defines.svh: offsets, codes, counts and timing figures of the converter control.
// assumes it is included by bare name from each design file that needs a figure.
`ifndef ADC_CTRL_DEFINES_SVH
`define ADC_CTRL_DEFINES_SVH

// result and address widths
`define RESULT_BITS 10
`define ADDR_BITS 4
// serial frame figures, counted in serial clock edges
`define ADDR_RISES 5'h04
`define SAMPLE_START_FALL 5'h04
`define CONV_START_FALL 5'h0A
`define LEVEL_CLEAR_FALL 5'h02
`define SHORT_FRAME 5'h0A
`define LONG_FRAME 5'h10
// channel address codes
`define CODE_INPUT_FIRST 4'h0
`define CODE_INPUT_LAST 4'h4
`define CODE_TEST_HALF 4'hB
`define CODE_TEST_LOW 4'hC
`define CODE_TEST_HIGH 4'hD
// switch vector: five inputs, then half, low and high test levels
`define NUM_INPUTS 5
`define NUM_SWITCHES 8
`define TEST_CODE_OFFSET 6
// reset values and successive-approximation start code
`define RESULT_RESET 10'h000
`define DAC_MID 10'h200
`define MSB_INDEX 4'h9
// timing: reference clock period and derived counts
`define REF_CLK_NS 25
`define BBM_NS 50
`define BBM_CYCLES ((`BBM_NS + `REF_CLK_NS - 1) / `REF_CLK_NS)
`define BIT_SETTLE_NS 1000
`define BIT_SETTLE_CYCLES ((`BIT_SETTLE_NS + `REF_CLK_NS - 1) / `REF_CLK_NS)
`define CNT_BITS 8
`define FIFO_DEPTH 8

`endif

// ==== hdl/adc_ctrl_pkg.sv ====
// adc_ctrl_pkg: types shared by the converter control files.
// assumes adc_ctrl_defines.svh is on the include path.
`include "adc_ctrl_defines.svh"

package adc_ctrl_pkg;
   // conversion sequencer states
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_BREAK = 3'h1,
      ST_SAMPLE = 3'h2,
      ST_CONVERT = 3'h3,
      ST_PUSH = 3'h4
   } conv_state_t;
   // one conversion result
   typedef logic [`RESULT_BITS-1:0] result_t;
   // one channel address
   typedef logic [`ADDR_BITS-1:0] chan_addr_t;
   // one close bit per analog switch
   typedef logic [`NUM_SWITCHES-1:0] switch_vec_t;
endpackage

// ==== hdl/result_fifo.sv ====
// result_fifo: flip-flop FIFO with valid/ready on both sides, single clock.
// assumes both sides run on clk; srst is synchronous and active high.
`timescale 1ns/1ps
`default_nettype none

module result_fifo #(
   parameter int WIDTH = 10,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PW = $clog2(DEPTH);

   // pointers wrap naturally, so depth must be a power of two
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("result_fifo depth must be a power of two, at least 2");
   end

   logic [WIDTH-1:0] mem_reg [DEPTH]; // storage entries
   logic [PW-1:0] wr_ptr_reg; // next entry to fill
   logic [PW-1:0] rd_ptr_reg; // oldest entry
   logic [PW:0] count_reg; // entries held
   logic push; // accepted write
   logic pop; // accepted read

   assign in_ready = (count_reg != (PW+1)'(DEPTH));
   assign out_valid = (count_reg != '0);
   assign out_data = mem_reg[rd_ptr_reg];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // write side
   always_ff @(posedge clk) begin
      if (push) begin
         mem_reg[wr_ptr_reg] <= in_data;
      end
   end

   // pointer and fill level
   always_ff @(posedge clk) begin
      if (srst) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         end
         count_reg <= count_reg + (PW+1)'(push) - (PW+1)'(pop);
      end
   end
endmodule // result_fifo

`default_nettype wire

// ==== hdl/adc_channel_select_test_modes.sv ====
// adc_channel_select_test_modes: serial port, channel select and conversion control.
// assumes a host drives sclk, cs_n and din; an analog comparator answers comp_above.
//
// Overview of operation
// [R1] address 0..4 picks analog input 0..4
// [R2] codes B, C, D sample test levels
// [R3] test levels convert to 200, 000, 3FF
// [R4] open old switch before closing new
// [R5] result saturates at zero and full scale
// [R6] host gives 11th rising edge before done
// [R7] full duplex: old result out, address in
// [R8] end-of-conversion output marks result ready
// [R9] host sends only valid channel codes
// [R10] address MSB first, first four rises
// [R11] result MSB first, low after tenth fall
// [R12] eoc low at tenth fall, high when ready
// [R13] held select: exactly 10 or 16 clocks
`include "adc_ctrl_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module adc_channel_select_test_modes #(
   parameter int BIT_SETTLE_CYCLES = `BIT_SETTLE_CYCLES,
   parameter int BBM_CYCLES = `BBM_CYCLES,
   parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic din,
   input wire logic long_frame,
   input wire logic comp_above,
   output logic dout,
   output logic dout_oe,
   output logic eoc,
   output adc_ctrl_pkg::switch_vec_t switch_close,
   output logic sample_en,
   output adc_ctrl_pkg::result_t dac_code
);
   import adc_ctrl_pkg::*;

   // the step counter is 8 bits wide; longer settle times would need a wider counter.
   // a trial bit needs three cycles at least: the comparator answer to a new trial
   // code still has to pass both synchroniser stages before the bit is decided
   if (BIT_SETTLE_CYCLES < 3 || BIT_SETTLE_CYCLES > 255 ||
       BBM_CYCLES < 1 || BBM_CYCLES > 255) begin : g_bad_count
      $error("settle count must lie in 3..255, break count in 1..255");
   end

   // link side, clocked by sclk; all but the strap stages cleared while chip select is high
   logic [4:0] rise_cnt_reg; // rising edges seen in this frame
   logic [4:0] fall_cnt_reg; // falling edges seen in this frame
   logic [4:0] rise_inc; // ordinal of the current rising edge
   logic [4:0] fall_inc; // ordinal of the current falling edge
   logic [4:0] frame_len; // frame length while select is held
   chan_addr_t addr_shift_reg; // address shifted in from din
   logic addr_lvl_reg; // high once the address is complete
   logic conv_lvl_reg; // high once the sample phase has ended
   logic long_s1_reg; // frame-length strap, first stage
   logic long_s2_reg; // frame-length strap, second stage
   result_t dout_shift; // result moved up to the bit on show

   // reference side
   logic cs_s1_reg; // chip select synchroniser
   logic cs_s2_reg;
   logic addr_s1_reg; // address-ready synchroniser
   logic addr_s2_reg;
   logic addr_s3_reg; // delayed copy for the edge
   logic conv_s1_reg; // conversion-start synchroniser
   logic conv_s2_reg;
   logic conv_s3_reg;
   logic comp_s1_reg; // comparator synchroniser
   logic comp_s2_reg;
   logic addr_evt; // one-cycle: new address available
   logic conv_evt; // one-cycle: sample phase over
   conv_state_t state_reg; // sequencer state
   logic [`CNT_BITS-1:0] cnt_reg; // cycles in the current step
   logic step_done; // settle time of one trial bit spent
   logic break_done; // all-open interval spent
   chan_addr_t chan_reg; // address for the next conversion
   switch_vec_t sw_want; // switch that the address asks for
   switch_vec_t sw_reg; // switch drive
   logic sample_reg; // sample phase indicator
   result_t dac_reg; // trial code
   logic [3:0] bit_idx_reg; // bit under trial
   logic eoc_reg; // result ready flag
   result_t result_reg; // result shown on the serial output
   logic dout_oe_reg; // output driver enable
   logic fifo_in_ready; // room for a finished result
   logic fifo_out_valid; // a result waits to be published
   result_t fifo_out_data;

   // link-side helpers
   assign frame_len = long_s2_reg ? `LONG_FRAME : `SHORT_FRAME;
   assign rise_inc = rise_cnt_reg + 5'h01;
   assign fall_inc = fall_cnt_reg + 5'h01;

   // strap crosses into the link domain; a data path, so no reset is needed
   always_ff @(negedge sclk) begin
      long_s1_reg <= long_frame;
      long_s2_reg <= long_s1_reg;
   end

   // rising edges: take the address, then ignore din
   always_ff @(posedge sclk or posedge cs_n) begin
      if (cs_n) begin
         rise_cnt_reg <= 5'h00;
         addr_shift_reg <= 4'h0;
      end else begin
         // [R10] address MSB first
         if (rise_cnt_reg < `ADDR_RISES) begin
            addr_shift_reg <= {addr_shift_reg[`ADDR_BITS-2:0], din};
         end
         // [R13] frame wraps at length
         if (rise_inc == frame_len) begin
            rise_cnt_reg <= 5'h00;
         end else begin
            rise_cnt_reg <= rise_inc;
         end
      end
   end

   // falling edges: count the frame and mark sample start and conversion start
   always_ff @(negedge sclk or posedge cs_n) begin
      if (cs_n) begin
         fall_cnt_reg <= 5'h00;
      end else if (fall_inc == frame_len) begin
         // [R13] held select wraps here
         fall_cnt_reg <= 5'h00;
      end else begin
         fall_cnt_reg <= fall_inc;
      end
   end

   // address-ready level; it stays up until select goes high or, with select held, until fall 2 of the next frame
   always_ff @(negedge sclk or posedge cs_n) begin
      if (cs_n) begin
         addr_lvl_reg <= 1'b0;
      end else if (fall_inc == `SAMPLE_START_FALL) begin
         addr_lvl_reg <= 1'b1;
      end else if (fall_inc == `LEVEL_CLEAR_FALL) begin
         addr_lvl_reg <= 1'b0;
      end
   end

   // conversion-start level; a level, not a toggle, so select high cannot fake an event
   always_ff @(negedge sclk or posedge cs_n) begin
      if (cs_n) begin
         conv_lvl_reg <= 1'b0;
      end else if (fall_inc == `CONV_START_FALL) begin
         // [R12] tenth fall starts conversion
         conv_lvl_reg <= 1'b1;
      end else if (fall_inc == `LEVEL_CLEAR_FALL) begin
         conv_lvl_reg <= 1'b0;
      end
   end

   // serial output: the result word is static while eoc is high, so it is read across
   // domains without a crossing; eoc low forces a low level during conversion
   assign dout_shift = result_reg << fall_cnt_reg;
   // [R11] MSB first, then zeros
   // [R7] old result goes out
   assign dout = eoc_reg && (fall_cnt_reg < `CONV_START_FALL) &&
                 dout_shift[`RESULT_BITS-1];
   assign dout_oe = dout_oe_reg;

   // pin and link levels into the reference domain
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         cs_s1_reg <= 1'b1;
         cs_s2_reg <= 1'b1;
         addr_s1_reg <= 1'b0;
         addr_s2_reg <= 1'b0;
         addr_s3_reg <= 1'b0;
         conv_s1_reg <= 1'b0;
         conv_s2_reg <= 1'b0;
         conv_s3_reg <= 1'b0;
         comp_s1_reg <= 1'b0;
         comp_s2_reg <= 1'b0;
      end else begin
         cs_s1_reg <= cs_n;
         cs_s2_reg <= cs_s1_reg;
         addr_s1_reg <= addr_lvl_reg;
         addr_s2_reg <= addr_s1_reg;
         addr_s3_reg <= addr_s2_reg;
         conv_s1_reg <= conv_lvl_reg;
         conv_s2_reg <= conv_s1_reg;
         conv_s3_reg <= conv_s2_reg;
         comp_s1_reg <= comp_above;
         comp_s2_reg <= comp_s1_reg;
      end
   end

   assign addr_evt = addr_s2_reg && !addr_s3_reg;
   assign conv_evt = conv_s2_reg && !conv_s3_reg;
   assign step_done = (cnt_reg == `CNT_BITS'(BIT_SETTLE_CYCLES - 1));
   assign break_done = (cnt_reg == `CNT_BITS'(BBM_CYCLES - 1));

   // output driver follows the synchronised chip select
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         dout_oe_reg <= 1'b0;
      end else begin
         dout_oe_reg <= !cs_s2_reg;
      end
   end

   // channel address latch; the address shift register has been still since the fourth rise
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         chan_reg <= `CODE_INPUT_FIRST;
      end else if (addr_evt) begin
         // [R7] address picks next channel
         chan_reg <= addr_shift_reg;
      end
   end

   // address decode, one comparator per switch
   for (genvar i = 0; i < `NUM_SWITCHES; i++) begin : g_decode
      if (i < `NUM_INPUTS) begin : g_input
         // [R1] inputs 0 to 4
         assign sw_want[i] = (chan_reg == `ADDR_BITS'(i));
      end else begin : g_test
         // [R2] test codes B to D
         assign sw_want[i] = (chan_reg == `ADDR_BITS'(i + `TEST_CODE_OFFSET));
      end
   end

   // sequencer: conversion start outranks a new address
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         state_reg <= ST_IDLE;
      end else if (conv_evt) begin
         state_reg <= ST_CONVERT;
      end else if (addr_evt) begin
         state_reg <= ST_BREAK;
      end else begin
         unique case (state_reg)
            ST_IDLE: begin
               state_reg <= ST_IDLE;
            end
            ST_BREAK: begin
               if (break_done) begin
                  state_reg <= ST_SAMPLE;
               end
            end
            ST_SAMPLE: begin
               state_reg <= ST_SAMPLE;
            end
            ST_CONVERT: begin
               if (step_done && bit_idx_reg == 4'h0) begin
                  state_reg <= ST_PUSH;
               end
            end
            ST_PUSH: begin
               // a full buffer stalls the sequencer here
               if (fifo_in_ready) begin
                  state_reg <= ST_IDLE;
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // step counter for the all-open interval and each trial bit
   always_ff @(posedge ref_clk) begin
      if (srst || conv_evt || addr_evt) begin
         cnt_reg <= '0;
      end else if ((state_reg == ST_BREAK && !break_done) ||
                   (state_reg == ST_CONVERT && !step_done)) begin
         cnt_reg <= cnt_reg + 1'b1;
      end else begin
         cnt_reg <= '0;
      end
   end

   // switch drive: every change passes through all-open first
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         sw_reg <= '0;
      end else if (conv_evt || addr_evt) begin
         // [R4] open before close
         sw_reg <= '0;
      end else if (state_reg == ST_BREAK && break_done) begin
         // [R4] close after the break
         sw_reg <= sw_want;
      end
   end

   // sample phase marker; test levels are taken onto the array only here
   always_ff @(posedge ref_clk) begin
      if (srst || conv_evt || addr_evt) begin
         sample_reg <= 1'b0;
      end else if (state_reg == ST_BREAK && break_done) begin
         // [R2] sample during sample phase
         sample_reg <= 1'b1;
      end
   end

   // successive approximation, one bit per settle interval
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         dac_reg <= `RESULT_RESET;
         bit_idx_reg <= `MSB_INDEX;
      end else if (conv_evt) begin
         dac_reg <= `DAC_MID;
         bit_idx_reg <= `MSB_INDEX;
      end else if (state_reg == ST_CONVERT && step_done) begin
         // [R5] keep bit only if input above
         // [R3] mid, low, high test levels
         dac_reg[bit_idx_reg] <= comp_s2_reg;
         if (bit_idx_reg != 4'h0) begin
            dac_reg[bit_idx_reg - 4'h1] <= 1'b1;
            bit_idx_reg <= bit_idx_reg - 4'h1;
         end
      end
   end

   // finished results queue here before they are published
   result_fifo #(
      .WIDTH(`RESULT_BITS),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(ref_clk),
      .srst(srst),
      .in_valid(state_reg == ST_PUSH),
      .in_ready(fifo_in_ready),
      .in_data(dac_reg),
      .out_valid(fifo_out_valid),
      .out_ready(!eoc_reg),
      .out_data(fifo_out_data)
   );

   // result register only changes while eoc is low, when the link is not reading it
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         result_reg <= `RESULT_RESET;
      end else if (fifo_out_valid && !eoc_reg) begin
         result_reg <= fifo_out_data;
      end
   end

   // end-of-conversion flag
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         eoc_reg <= 1'b1;
      end else if (conv_evt) begin
         // [R12] low when conversion begins
         eoc_reg <= 1'b0;
      end else if (fifo_out_valid && !eoc_reg) begin
         // [R8] high once result is ready
         eoc_reg <= 1'b1;
      end
   end

   assign eoc = eoc_reg;
   assign switch_close = sw_reg;
   assign sample_en = sample_reg;
   assign dac_code = dac_reg;
endmodule // adc_channel_select_test_modes

`default_nettype wire

// ==== verif/host_link.sv ====
// host_link: host serial port model, master of sclk, cs_n and din.
// assumes the bench calls xfer only while eoc is high.
`timescale 1ns/1ps
`default_nettype none

module host_link (
   output logic sclk,
   output logic cs_n,
   output logic din,
   input wire logic dout,
   input wire logic dout_oe
);
   // idle: clock still, select off
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      din = 1'b0;
   end

   // one frame of n clocks; the result is left aligned in r
   task automatic xfer(input logic [3:0] a, input int n, input bit hold, output logic [15:0] r);
      r = 16'h0000;
      if (cs_n) begin
         cs_n = 1'b0;
         #100;
      end
      for (int k = 0; k < n; k++) begin
         din = (k < 4) ? a[3-k] : ~din;
         #6 sclk = 1'b1;
         // a released output reads as unknown, so a late enable shows up as a mismatch
         r = {r[14:0], dout_oe ? dout : 1'bx};
         #6 sclk = 1'b0;
         // stretched low phases let the slow side see the level drop at fall 2
         // and the sample and start levels at falls 4 and 10
         if (k == 1 || k == 3 || k == 9) #150;
      end
      // 10 or 16 clocks; only 16-clock frames reach rise 11 before the result is done
      if (n < 16) r = r << (16 - n);
      if (!hold) begin
         #20 cs_n = 1'b1;
         din = ~din;
      end
   endtask
endmodule // host_link

`default_nettype wire

// ==== verif/adc_ctrl_chk.sv ====
// adc_ctrl_chk: concurrent checks on the converter control top ports.
// assumes bench runs the design with a 4-cycle bit settle time.
`timescale 1ns/1ps
`default_nettype none

module adc_ctrl_chk (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic din,
   input wire logic long_frame,
   input wire logic comp_above,
   input wire logic dout,
   input wire logic dout_oe,
   input wire logic eoc,
   input wire adc_ctrl_pkg::switch_vec_t switch_close,
   input wire logic sample_en,
   input wire adc_ctrl_pkg::result_t dac_code
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);

   // reset leaves an idle, open, ready converter
   a_reset_state: assert property ($fell(srst) |-> eoc && !dout_oe && switch_close == 8'h00
      && !sample_en && dac_code == 10'h000) else $error("bad state after reset");
   a_one_switch: assert property ($onehot0(switch_close))
      else $error("more than one switch closed");
   a_no_swap: assert property (($past(switch_close) != 8'h00 && switch_close != 8'h00)
      |-> switch_close == $past(switch_close)) else $error("switch swapped without break");
   a_break_gap: assert property ($rose(|switch_close) |-> $past(switch_close, 2) == 8'h00)
      else $error("break time too short");
   a_sample_closed: assert property (sample_en |-> |switch_close)
      else $error("sampling with no switch closed");
   a_conv_start: assert property ($fell(eoc) |-> ##[0:1] (dac_code == 10'h200
      && switch_close == 8'h00)) else $error("conversion start wrong");
   a_conv_span: assert property ($fell(eoc) |-> !eoc [*8])
      else $error("conversion ended too soon");
   a_conv_done: assert property ($fell(eoc) |-> ##[1:1000] eoc)
      else $error("conversion never completed");
   a_oe_on: assert property ($fell(cs_n) |-> ##[1:4] dout_oe) else $error("dout not enabled");
   a_oe_off: assert property ($rose(cs_n) |-> ##[1:4] !dout_oe) else $error("dout not released");
   a_dout_busy: assert property ((!eoc && dout_oe) |-> !dout)
      else $error("dout not low during conversion");

   c_done: cover property ($rose(eoc));
   c_close: cover property ($rose(|switch_close));
   c_select: cover property ($fell(cs_n));
endmodule // adc_ctrl_chk

bind adc_channel_select_test_modes adc_ctrl_chk adc_ctrl_chk_i (.ref_clk, .srst, .sclk,
   .cs_n, .din, .long_frame, .comp_above, .dout, .dout_oe, .eoc, .switch_close,
   .sample_en, .dac_code);

`default_nettype wire

// ==== verif/adc_channel_select_test_modes_test.sv ====
// adc_channel_select_test_modes_test: self-checking bench with host and comparator models.
// assumes the host model above and the design package are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_fail++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end

module adc_channel_select_test_modes_test;
   import adc_ctrl_pkg::*;
   logic ref_clk, srst, long_frame, comp_above, dout, dout_oe, eoc, sample_en, sclk, cs_n, din;
   switch_vec_t switch_close, sw_last;
   result_t dac_code;
   int n_fail, check_count, cyc, held;
   // analog levels: inputs 0..4 (two beyond the rails), then half, low, high
   int lvl [8] = '{341, 682, 240, 2000, -40, 512, 0, 1023};
   result_t exp_in [5] = '{10'h155, 10'h2AA, 10'h0F0, 10'h3FF, 10'h000};

   // four cycles per trial bit leave room for the comparator synchroniser
   adc_channel_select_test_modes #(.BIT_SETTLE_CYCLES(4)) adc_channel_select_test_modes_i (
      .ref_clk, .srst, .sclk, .cs_n, .din, .long_frame, .comp_above, .dout, .dout_oe, .eoc,
      .switch_close, .sample_en, .dac_code);
   host_link host_link_i (.sclk, .cs_n, .din, .dout, .dout_oe);

   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   // sample-and-hold plus comparator; remembers the last closed switch
   always @(negedge ref_clk) begin
      for (int i = 0; i < 8; i++) if (switch_close[i]) held = lvl[i];
      if (|switch_close) sw_last <= switch_close;
      comp_above <= held >= int'(dac_code);
   end

   // hang guard
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc > 20000) begin
         n_fail++;
         give_verdict();
      end
   end

   task automatic give_verdict();
      $display("checks %0d failures %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   // one frame, then wait for the conversion under a bound
   task automatic frame(input chan_addr_t a, input int n, input bit hold, output logic [15:0] r);
      int k;
      @(negedge ref_clk);
      host_link_i.xfer(a, n, hold, r);
      k = 0;
      while (eoc !== 1'b1 && k < 1000) begin
         @(negedge ref_clk);
         k++;
      end
      `CHK(eoc, 1'b1)
   endtask

   task automatic t_reset();
      `CHK(eoc, 1'b1)
      `CHK(dout_oe, 1'b0)
      `CHK(switch_close, 8'h00)
      $display("t_reset done");
   endtask

   // self-test codes read back through 16-clock frames with zero padding
   task automatic t_selftest();
      logic [15:0] r;
      frame(4'hB, 16, 1'b0, r);
      `CHK(r, 16'h0000)
      `CHK(sw_last, 8'h20)
      frame(4'hC, 16, 1'b0, r);
      `CHK(r, 16'h8000)
      `CHK(sw_last, 8'h40)
      frame(4'hD, 16, 1'b0, r);
      `CHK(r, 16'h0000)
      `CHK(sw_last, 8'h80)
      $display("t_selftest done");
   endtask

   // every input, each result read one frame later, two saturating
   task automatic t_inputs();
      logic [15:0] r;
      for (int i = 0; i < 5; i++) begin
         frame(4'(i), 10, 1'b0, r);
         `CHK(sw_last, 8'(1 << i))
         `CHK(r, {(i == 0) ? 10'h3FF : exp_in[i-1], 6'h00})
      end
      $display("t_inputs done");
   endtask

   // select held low over back-to-back frames, 10 clocks and then 16 clocks
   task automatic t_held();
      logic [15:0] r;
      long_frame = 1'b0;
      frame(4'h0, 10, 1'b1, r);
      `CHK(r[15:6], exp_in[4])
      frame(4'h1, 10, 1'b1, r);
      `CHK(r[15:6], exp_in[0])
      frame(4'h0, 10, 1'b0, r);
      `CHK(r[15:6], exp_in[1])
      // long strap: the first 16-clock frame starts a held run of two
      long_frame = 1'b1;
      frame(4'hD, 16, 1'b1, r);
      `CHK(r, {exp_in[0], 6'h00})
      frame(4'hC, 16, 1'b0, r);
      `CHK(r, 16'hFFC0)
      $display("t_held done");
   endtask

   initial begin
      srst = 1'b1;
      // 16-clock strap: select-toggled frames longer than 10 clocks must not wrap at 10
      long_frame = 1'b1;
      repeat (10) @(negedge ref_clk);
      srst = 1'b0;
      @(negedge ref_clk);
      t_reset();
      t_selftest();
      t_inputs();
      t_held();
      give_verdict();
   end
endmodule // adc_channel_select_test_modes_test

`default_nettype wire
